// ==== pkg/bui_pkg.sv ====
// constants and carrier types for the bus unit initialisation block
// assumes one 200 MHz clock and a synchronous active-low reset
package bui_pkg;

  localparam int          ADDR_W       = 32;
  localparam int          INIT_HI_BIT  = 31;
  localparam int          INIT_LO_BIT  = 30;
  localparam int          WAY0_BIT     = 15;
  localparam int          WAY1_BIT     = 16;
  localparam logic [3:0]  IDENT_TYPE   = 4'h7;
  localparam logic [1:0]  IDENT_WORDS  = 2'h2;
  localparam int          IDN_LSB      = 0;
  localparam int          DRV_LSB      = 8;
  localparam int          CNT_LSB      = 12;
  localparam logic [7:0]  CONTAIN_RST  = 8'hFF;
  localparam logic [3:0]  START_PAT    = 4'hC;
  localparam logic [4:0]  LATCH_DLY    = 5'h1C;
  localparam int          CHAIN_W      = 38;
  localparam int          VIS_W        = 32;
  localparam int          HALF_W       = 16;
  localparam int          HID_W        = 6;
  localparam logic [2:0]  SLOW_WAIT    = 3'h3;
  localparam int          FIFO_DEPTH   = 16;
  localparam logic [1:0]  COM_ALT_CODE = 2'h2;
  localparam logic [1:0]  NO_REPORT    = 2'h0;
  localparam logic [1:0]  STROBE_ON_N  = 2'h0;
  localparam logic [1:0]  STROBE_OFF_N = 2'h3;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
  } bui_lreq_t;

  localparam int LREQ_W = ADDR_W + 1;

  typedef struct packed {
    logic       hdr;
    logic       dvalid;
    logic       msg;
    logic [3:0] mtype;
    logic       wr;
    logic [1:0] len;
    logic [31:0] ad;
    logic       ident_sel;
  } bui_pb_t;

  typedef struct packed {
    logic       msg_recog_en;
    logic       mem_recog_en;
    logic       cache_en;
    logic       prefetch_en;
    logic       err_rpt_en;
    logic       bus_sw_dis;
    logic       com_rpt_en;
    logic       drive_pin;
    logic       test_en;
    logic       disable_init_ram;
    logic [7:0] containment_ident;
  } bui_ctl_t;

  localparam bui_ctl_t CTL_RST = '{msg_recog_en: 1'b1, mem_recog_en: 1'b0,
                                  cache_en: 1'b0, prefetch_en: 1'b0,
                                  err_rpt_en: 1'b0, bus_sw_dis: 1'b0,
                                  com_rpt_en: 1'b0, drive_pin: 1'b0,
                                  test_en: 1'b0, disable_init_ram: 1'b0,
                                  containment_ident: CONTAIN_RST};

  typedef struct packed {
    logic [3:0] physical_ident;
    logic [3:0] logical_ident;
    logic [1:0] drive_slot_field;
    logic [3:0] count_slot_field;
  } bui_ident_t;

  typedef enum logic [2:0] {
    ID_IDLE = 3'b001,
    ID_D1   = 3'b010,
    ID_D2   = 3'b100
  } bui_id_state_t;

endpackage : bui_pkg

// ==== rtl/bui_top.sv ====
// initialisation logic of the bus expansion unit: init-ram service, reset
// defaults, identify-device order and the serial board-parameter chain.
// assumes packet-bus and parameter-pin inputs are asynchronous to clk_i.
`timescale 1ns/100ps

module bui_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } bui_fifo_st_t;

  bui_fifo_st_t st;
  bui_fifo_st_t next_st;
  logic         push;
  logic         pop;

  assign in_ready_o  = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = st.mem[st.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_i;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : bui_fifo

module bui_top (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  // local bus memory request
  input  wire logic                     lreq_valid_i,
  output logic                          lreq_ready_o,
  input  wire bui_pkg::bui_lreq_t       lreq_i,
  output logic                          lfwd_valid_o,
  output logic [bui_pkg::ADDR_W-1:0]    lfwd_addr_o,
  // local sram sequencing
  output logic [bui_pkg::ADDR_W-1:0]    sram_addr_o,
  output logic                          way_select_zero_o,
  output logic                          way_select_one_o,
  output logic [1:0]                    sram_write_strobes_n_o,
  output logic                          lready_o,
  // packet bus snoop
  input  wire bui_pkg::bui_pb_t         pb_i,
  // control and status
  input  wire logic                     ctl_wr_i,
  input  wire bui_pkg::bui_ctl_t        ctl_i,
  input  wire logic                     clr_altered_i,
  input  wire logic                     unit_failed_i,
  output bui_pkg::bui_ctl_t             ctl_o,
  output logic                          cache_inval_o,
  output logic                          param_altered_o,
  output bui_pkg::bui_ident_t           ident_o,
  // serial board parameter register
  input  wire logic                     param_wr_i,
  input  wire logic [bui_pkg::VIS_W-1:0] param_wdata_i,
  output logic [bui_pkg::VIS_W-1:0]     serial_board_parameters_o,
  // parameter pin, open drain, and error report lines
  input  wire logic                     param_pin_i,
  output logic                          param_pin_o,
  output logic                          param_pin_oe_o,
  output logic [1:0]                    bus_error_report_lines_o
);
  import bui_pkg::*;

  typedef struct packed {
    bui_pb_t              pb_s1;
    bui_pb_t              pb_s2;
    logic                 pin_s1;
    logic                 pin_s2;
    logic [3:0]           hist;
    logic                 counting;
    logic [4:0]           cnt;
    logic [CHAIN_W-1:0]   chain;
    bui_ctl_t             ctl;
    logic                 altered;
    logic                 inval;
    bui_ident_t           ident;
    bui_id_state_t        id_st;
    logic [1:0]           ber;
    logic                 pin_oe;
    logic                 own_s1;
    logic                 own_s2;
    logic [1:0]           strobes_n;
    logic                 fwd_valid;
    logic [ADDR_W-1:0]    fwd_addr;
    logic                 seq_busy;
    logic [2:0]           seq_cnt;
    bui_lreq_t            seq_req;
    logic                 ready;
  } bui_st_t;

  bui_st_t    st;
  bui_st_t    next_st;
  logic       in_valid;
  logic       in_ready;
  logic       hit;
  logic       q_valid;
  logic       q_ready;
  bui_lreq_t  q_data;
  logic       start;

  assign hit      = lreq_i.addr[INIT_HI_BIT] && !lreq_i.addr[INIT_LO_BIT]
                    && !st.ctl.disable_init_ram;
  assign in_valid = lreq_valid_i && hit;
  assign q_ready  = !st.seq_busy;
  assign start    = (st.hist == START_PAT);

  bui_fifo #(
    .WIDTH (LREQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (in_valid),
    .in_ready_o  (in_ready),
    .in_data_i   (lreq_i),
    .out_valid_o (q_valid),
    .out_ready_i (q_ready),
    .out_data_o  (q_data)
  );

  assign lreq_ready_o = hit ? in_ready : 1'b1;

  always_comb begin
    next_st        = st;
    next_st.pb_s1  = pb_i;
    next_st.pb_s2  = st.pb_s1;
    next_st.pin_s1 = param_pin_i;
    next_st.pin_s2 = st.pin_s1;
    // own pin drive tracked through the same stages so it never reads as a start
    next_st.own_s1 = st.pin_oe;
    next_st.own_s2 = st.own_s1;
    next_st.hist   = {st.hist[2:0], st.pin_s2 | st.own_s2};
    next_st.inval  = 1'b0;
    next_st.ber    = NO_REPORT;
    next_st.ready  = 1'b0;

    // misses go to the memory recognizer only when software enabled it;
    // the unit itself never issues a request of its own
    next_st.fwd_valid = lreq_valid_i && !hit && st.ctl.mem_recog_en;
    next_st.fwd_addr  = lreq_i.addr;

    // slow cache timing: strobes held SLOW_WAIT cycles, then one ready pulse
    if (!st.seq_busy) begin
      if (q_valid) begin
        next_st.seq_busy = 1'b1;
        next_st.seq_cnt  = SLOW_WAIT;
        next_st.seq_req  = q_data;
      end
    end else if (st.seq_cnt == 3'h1) begin
      next_st.seq_busy = 1'b0;
      next_st.seq_cnt  = 3'h0;
      next_st.ready    = 1'b1;
    end else begin
      next_st.seq_cnt = st.seq_cnt - 3'h1;
    end
    next_st.strobes_n = (next_st.seq_busy && next_st.seq_req.wr) ? STROBE_ON_N
                                                                : STROBE_OFF_N;

    if (ctl_wr_i) begin
      next_st.ctl = ctl_i;
    end
    if (clr_altered_i) begin
      next_st.altered = 1'b0;
    end

    // identify-device order snooped on the packet bus
    unique case (st.id_st)
      ID_IDLE: begin
        if (st.pb_s2.hdr && st.pb_s2.msg && st.pb_s2.wr
            && st.pb_s2.mtype == IDENT_TYPE && st.pb_s2.len == IDENT_WORDS) begin
          next_st.id_st = ID_D1;
        end
      end
      ID_D1: begin
        if (st.pb_s2.dvalid) begin
          next_st.id_st = st.pb_s2.ident_sel ? ID_D2 : ID_IDLE;
        end
      end
      ID_D2: begin
        if (st.pb_s2.dvalid) begin
          next_st.ident.physical_ident   = st.pb_s2.ad[IDN_LSB +: 4];
          next_st.ident.logical_ident    = st.pb_s2.ad[IDN_LSB +: 4];
          next_st.ident.drive_slot_field = st.pb_s2.ad[DRV_LSB +: 2];
          next_st.ident.count_slot_field = st.pb_s2.ad[CNT_LSB +: 4];
          next_st.id_st                  = ID_IDLE;
        end
      end
    endcase

    if (param_wr_i) begin
      next_st.chain = {param_wdata_i[HALF_W-1:0], {HID_W{1'b0}},
                       param_wdata_i[VIS_W-1:HALF_W]};
    end

    // serial start: clear test, flag altered, report once
    if (start) begin
      next_st.ctl.test_en = 1'b0;
      next_st.altered     = 1'b1;
      next_st.counting    = 1'b1;
      next_st.cnt         = LATCH_DLY;
      if (st.ctl.com_rpt_en && !st.altered) begin
        next_st.ber = COM_ALT_CODE;
      end
    end else if (st.counting) begin
      if (st.cnt == 5'h1) begin
        next_st.counting = 1'b0;
        next_st.chain    = {st.pin_s2, st.chain[CHAIN_W-1:1]};
      end
      next_st.cnt = st.cnt - 5'h1;
    end

    // permanent-error drive is suspended from a serial start until software clears altered
    next_st.pin_oe = (st.ctl.drive_pin || unit_failed_i) && !st.altered;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st       <= '0;
      st.ctl   <= CTL_RST;
      st.inval <= 1'b1;
      st.id_st <= ID_IDLE;
      st.strobes_n <= STROBE_OFF_N;
    end else begin
      st <= next_st;
    end
  end

  assign ctl_o                     = st.ctl;
  assign cache_inval_o             = st.inval;
  assign param_altered_o           = st.altered;
  assign ident_o                   = st.ident;
  assign lfwd_valid_o              = st.fwd_valid;
  assign lfwd_addr_o               = st.fwd_addr;
  assign sram_addr_o               = st.seq_req.addr;
  assign way_select_zero_o         = st.seq_req.addr[WAY0_BIT];
  assign way_select_one_o          = st.seq_req.addr[WAY1_BIT];
  assign sram_write_strobes_n_o    = st.strobes_n;
  assign lready_o                  = st.ready;
  // first bit shifted lands in bit16, last in bit15, hidden bits unread
  assign serial_board_parameters_o = {st.chain[HALF_W-1:0],
                                      st.chain[CHAIN_W-1:CHAIN_W-HALF_W]};
  assign param_pin_o               = 1'b0;
  assign param_pin_oe_o            = st.pin_oe;
  assign bus_error_report_lines_o  = st.ber;
endmodule : bui_top

// ==== dv/bui_sva.sv ====
// assertions on the ports of the bus unit initialisation block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module bui_sva (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic               lreq_valid_i,
  input wire logic               lreq_ready_o,
  input wire bui_pkg::bui_lreq_t lreq_i,
  input wire logic               lfwd_valid_o,
  input wire logic [31:0]        lfwd_addr_o,
  input wire logic [31:0]        sram_addr_o,
  input wire logic               way_select_zero_o,
  input wire logic               way_select_one_o,
  input wire logic [1:0]         sram_write_strobes_n_o,
  input wire logic               lready_o,
  input wire bui_pkg::bui_ctl_t  ctl_o,
  input wire logic               cache_inval_o,
  input wire logic               param_altered_o,
  input wire bui_pkg::bui_ident_t ident_o,
  input wire logic               param_pin_i,
  input wire logic               param_pin_oe_o,
  input wire logic               unit_failed_i,
  input wire logic [1:0]         bus_error_report_lines_o
);
  import bui_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire take = lreq_valid_i & lreq_ready_o;
  wire hit  = lreq_i.addr[INIT_HI_BIT] & !lreq_i.addr[INIT_LO_BIT] & !ctl_o.disable_init_ram;
  logic       pin_q;
  logic [3:0] steady;
  // cycles since the pin last moved, saturating
  always_ff @(posedge clk_i) begin
    pin_q  <= param_pin_i;
    steady <= (!nrst_i || param_pin_i != pin_q) ? 4'h0 : steady + {3'h0, steady != 4'hF};
  end
  sequence s_wr_on;
    (sram_write_strobes_n_o == STROBE_ON_N) [*3];
  endsequence
  property p_rst;
    disable iff (1'b0) !nrst_i |=> ctl_o == CTL_RST && cache_inval_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hit;
    take && hit |=> !lfwd_valid_o;
  endproperty
  a_hit: assert property (p_hit) else $error("hit forwarded");
  property p_fwd;
    lfwd_valid_o |-> $past(take && !hit && ctl_o.mem_recog_en)
                     && lfwd_addr_o == $past(lreq_i.addr);
  endproperty
  a_fwd: assert property (p_fwd) else $error("request originated");
  property p_way;
    lready_o |-> {way_select_one_o, way_select_zero_o} == sram_addr_o[16:15]
                 && sram_addr_o[31:30] == 2'h2;
  endproperty
  a_way: assert property (p_way) else $error("way select wrong");
  property p_slow;
    $fell(sram_write_strobes_n_o[0]) |->
      s_wr_on ##1 (lready_o && sram_write_strobes_n_o == STROBE_OFF_N);
  endproperty
  a_slow: assert property (p_slow) else $error("slow write timing wrong");
  property p_ber;
    bus_error_report_lines_o ==
      (($rose(param_altered_o) && $past(ctl_o.com_rpt_en)) ? COM_ALT_CODE : NO_REPORT);
  endproperty
  a_ber: assert property (p_ber) else $error("error report wrong");
  property p_start;
    $rose(param_altered_o) |-> !ctl_o.test_en && steady < 4'hC;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_drv;
    (unit_failed_i || ctl_o.drive_pin) && !param_altered_o |-> ##[1:2] param_pin_oe_o;
  endproperty
  a_drv: assert property (p_drv) else $error("pin not driven");
  property p_ident;
    $changed(ident_o) |-> ident_o.physical_ident == ident_o.logical_ident;
  endproperty
  a_ident: assert property (p_ident) else $error("identity split");
endmodule : bui_sva
bind bui_top bui_sva chk_u (.*);

// ==== dv/bui_brd_ctl.sv ====
// board controller model shifting bits in on the parameter pin
// assumes the bench resolves the open-drain pin with a pull-up
`timescale 1ns/100ps
module bui_brd_ctl (
  input  wire logic clk_i,
  output logic      drv_low_o
);
  initial drv_low_o = 1'b0;
  task automatic step(input int n, input logic lvl);
    repeat (n) @(posedge clk_i);
    #1 drv_low_o = !lvl;
  endtask : step
  task automatic send_bit(input logic b);
    step(1, 1'b1);
    step(3, 1'b0);
    step(3, b);
    repeat (36) @(posedge clk_i);
    #1;
  endtask : send_bit
  task automatic send_chain(input logic [37:0] v);
    for (int i = 37; i >= 0; i--) send_bit(v[i]);
  endtask : send_chain
endmodule : bui_brd_ctl

// ==== dv/bui_top_tb.sv ====
// self-checking bench for the bus unit initialisation block
// assumes the checker is bound and the board model drives the pin
`timescale 1ns/100ps
module bui_top_tb;
  import bui_pkg::*;
  logic clk_i = 0, nrst_i = 0, lreq_valid_i = 0, ctl_wr_i = 0, clr_altered_i = 0;
  logic unit_failed_i = 0, param_wr_i = 0, refused = 0, drv_low;
  logic [31:0] param_wdata_i = '0;
  bui_lreq_t   lreq_i = '0;
  bui_pb_t     pb_i = '0;
  bui_ctl_t    ctl_i = CTL_RST;
  logic lreq_ready_o, lfwd_valid_o, way_select_zero_o, way_select_one_o, lready_o;
  logic cache_inval_o, param_altered_o, param_pin_o, param_pin_oe_o;
  logic [31:0] lfwd_addr_o, sram_addr_o, serial_board_parameters_o;
  logic [1:0]  sram_write_strobes_n_o, bus_error_report_lines_o;
  bui_ctl_t    ctl_o;
  bui_ident_t  ident_o;
  int bad_count = 0, samples_checked = 0, n_iss = 0, n_srv = 0, n_fwd = 0, n_ber = 0;
  wire param_pin_i = !(drv_low | param_pin_oe_o);
  bui_top dut_u (.*);
  bui_brd_ctl brd_u (.clk_i(clk_i), .drv_low_o(drv_low));
  always #2.5 clk_i = !clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic reset_dut;
    nrst_i = 0;
    tick(20);
    chk(cache_inval_o, 1);
    nrst_i = 1;
    tick(2);
    chk(32'(ctl_o), 32'(CTL_RST));
  endtask : reset_dut
  task automatic mreq(input logic [31:0] a, input logic w);
    lreq_i = '{wr: w, addr: a};
    lreq_valid_i = 1;
    for (int i = 0; i < 64 && !lreq_ready_o; i++) begin
      refused = 1;
      tick();
    end
    chk(lreq_ready_o, 1);
    tick();
  endtask : mreq
  task automatic wrctl(input bui_ctl_t c);
    ctl_i = c;
    ctl_wr_i = 1;
    tick();
    ctl_wr_i = 0;
    tick(3);
  endtask : wrctl
  task automatic idord(input logic [3:0] t, input logic sel, input logic [31:0] d);
    pb_i = '{hdr: 1'b1, msg: 1'b1, wr: 1'b1, mtype: t, len: IDENT_WORDS, default: '0};
    tick();
    pb_i = '{dvalid: 1'b1, ad: {31'h0, sel}, ident_sel: sel, default: '0};
    tick();
    pb_i = '{dvalid: 1'b1, ad: d, ident_sel: d[0], default: '0};
    tick();
    pb_i = '0;
    tick(6);
  endtask : idord
  // way bits of served hits follow the issue order
  always @(negedge clk_i) if (nrst_i) begin
    if (lready_o === 1'b1) begin
      chk({way_select_one_o, way_select_zero_o}, 32'(n_srv % 4));
      n_srv++;
    end
    n_fwd += int'(lfwd_valid_o === 1'b1);
    n_ber += int'(bus_error_report_lines_o === COM_ALT_CODE);
  end
  initial begin
    repeat (8000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    bui_ctl_t c;
    reset_dut();
    mreq(32'h4000_0000, 0);
    mreq(32'hC000_0010, 1);
    for (int i = 0; i < 24; i++) begin
      mreq(32'h8000_0000 | (32'(n_iss % 4) << 15), n_iss[0]);
      n_iss++;
    end
    lreq_valid_i = 0;
    tick(200);
    chk(n_srv, 24);
    chk(refused, 1);
    chk(n_fwd, 0);
    c = CTL_RST;
    c.mem_recog_en = 1;
    c.com_rpt_en = 1;
    c.test_en = 1;
    c.containment_ident = 8'h3C;
    wrctl(c);
    mreq(32'h0000_1234, 0);
    lreq_valid_i = 0;
    tick(3);
    chk(n_fwd, 1);
    chk(lfwd_addr_o, 32'h0000_1234);
    idord(IDENT_TYPE, 1, 32'h0000_B106);
    chk(ident_o, 14'h199B);
    idord(IDENT_TYPE, 0, 32'h0000_0F0C);
    chk(ident_o, 14'h199B);
    idord(4'h6, 1, 32'h0000_0F0C);
    chk(ident_o, 14'h199B);
    unit_failed_i = 1;
    tick(4);
    chk(param_pin_oe_o, 1);
    unit_failed_i = 0;
    c.drive_pin = 1;
    wrctl(c);
    chk(param_pin_oe_o, 1);
    c.drive_pin = 0;
    wrctl(c);
    chk(param_pin_oe_o, 0);
    chk(ctl_o.test_en, 1);
    param_wdata_i = 32'hFFFF_FFFF;
    param_wr_i = 1;
    tick();
    param_wr_i = 0;
    tick();
    chk(serial_board_parameters_o, 32'hFFFF_FFFF);
    repeat (6) brd_u.send_bit(1'b1);
    chk(serial_board_parameters_o, 32'h03FF_FFFF);
    brd_u.send_chain(38'h20_0000_0000);
    chk(serial_board_parameters_o, 32'h0001_0000);
    chk(param_altered_o, 1);
    chk(ctl_o.test_en, 0);
    chk(n_ber, 1);
    clr_altered_i = 1;
    tick();
    clr_altered_i = 0;
    brd_u.send_chain(38'h1);
    chk(serial_board_parameters_o, 32'h0000_8000);
    chk(n_ber, 2);
    reset_dut();
    chk(param_altered_o, 0);
    finish_test();
  end
endmodule : bui_top_tb
